/* hw/pin_dp_config_regs.sv */
/*
 holds the pin pair configuration register, the datapath control
 register, the pad control of two pins and the datapath mode decode.
 assumes a simple internal register port on the core clock, remote
 loads as one-cycle strobes on the core clock, and asynchronous pins.
*/
`include "pin_dp_params.svh"

module pin_dp_config_regs
   import pin_dp_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // register port
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // forward channel loads from the remote serializer
   input wire logic i_remote_dp_load,
   input wire logic [7:0] i_remote_dp_data,
   input wire logic i_remote_pin_a_value,
   input wire logic i_remote_pin_b_value,
   input wire logic i_partner_has_protection,
   // pins
   input wire logic i_pin_a,
   input wire logic i_pin_b,
   input wire logic i_pin_a_functional,
   input wire logic i_pin_b_functional,
   output logic o_pin_a_out,
   output logic o_pin_a_oe,
   output logic o_pin_b_out,
   output logic o_pin_b_oe,
   output logic o_pin_a_input_value,
   output logic o_pin_b_input_value,
   // video datapath
   input wire logic i_pixel_data_valid,
   output logic o_pixel_valid_active,
   output logic o_video_pass_without_framing,
   output logic o_protection_enable,
   output logic o_packet_audio_enable,
   output logic o_audio_on_video_pins,
   output logic o_four_channel_audio,
   output logic o_depth_18_bit,
   output logic o_audio_in_band
);
   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0] pin_pair_config_reg;
   logic [7:0] pin_pair_config_next;
   logic [7:0] datapath_control_reg;
   logic [7:0] datapath_control_next;
   logic [1:0] pin_a_sync_reg;
   logic [1:0] pin_b_sync_reg;
   logic [1:0] valid_sync_reg;
   logic pin_a_in_reg;
   logic pin_b_in_reg;
   logic [7:0] rdata_reg;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   wire logic sel_pin;
   wire logic sel_dp;
   wire logic locked;
   wire logic remote_take;
   wire logic [7:0] dp_remote_merge;
   assign sel_pin = i_reg_addr == `PIN_PAIR_CONFIG_ADDR;
   assign sel_dp = i_reg_addr == `DATAPATH_CONTROL_ADDR;
   assign locked = datapath_control_reg[`DP_LOCK_BIT];
   // a load is refused while locked, keeping local values
   assign remote_take = i_remote_dp_load & ~locked;
   // only bits 6..0 follow the remote side; the lock stays local
   assign dp_remote_merge = (datapath_control_reg & ~`DP_REMOTE_MASK)
      | (i_remote_dp_data & `DP_REMOTE_MASK);

   // local write wins over a remote load in the same cycle
   assign pin_pair_config_next = (i_reg_wr & sel_pin) ? i_reg_wdata :
                                 pin_pair_config_reg;
   assign datapath_control_next = (i_reg_wr & sel_dp) ? i_reg_wdata :
      remote_take ? dp_remote_merge :
      datapath_control_reg;

   // register update
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pin_pair_config_reg <= `PIN_PAIR_CONFIG_RESET;
         datapath_control_reg <= `DATAPATH_CONTROL_RESET;
      end else begin
         pin_pair_config_reg <= pin_pair_config_next;
         datapath_control_reg <= datapath_control_next;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   wire logic [7:0] rdata_mux;
   assign rdata_mux = sel_pin ? pin_pair_config_reg :
                      sel_dp ? datapath_control_reg : 8'h00;
   // read data registered, one cycle after the address
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_mux;
      end
   end
   assign o_reg_rdata = rdata_reg;

   // ----------------------------------------------------------------
   // pin input synchronisers
   // ----------------------------------------------------------------
   // two stages before any logic; the second alone is read
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pin_a_sync_reg <= 2'b00;
         pin_b_sync_reg <= 2'b00;
         valid_sync_reg <= 2'b00;
      end else begin
         pin_a_sync_reg <= {pin_a_sync_reg[0], i_pin_a};
         pin_b_sync_reg <= {pin_b_sync_reg[0], i_pin_b};
         valid_sync_reg <= {valid_sync_reg[0], i_pixel_data_valid};
      end
   end

   // ----------------------------------------------------------------
   // pad control of both pins
   // ----------------------------------------------------------------
   pin_mode_t pin_a_mode;
   pin_mode_t pin_b_mode;

   pin_ctrl u_pin_a (
      .i_cfg(pin_pair_config_reg[`PIN_A_BASE +: 4]),
      .i_functional_value(i_pin_a_functional),
      .i_remote_value(i_remote_pin_a_value),
      .o_pin_out(o_pin_a_out),
      .o_pin_oe(o_pin_a_oe),
      .o_mode(pin_a_mode)
   );

   pin_ctrl u_pin_b (
      .i_cfg(pin_pair_config_reg[`PIN_B_BASE +: 4]),
      .i_functional_value(i_pin_b_functional),
      .i_remote_value(i_remote_pin_b_value),
      .o_pin_out(o_pin_b_out),
      .o_pin_oe(o_pin_b_oe),
      .o_mode(pin_b_mode)
   );

   // input value captured only in gp input mode, held otherwise
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pin_a_in_reg <= 1'b0;
         pin_b_in_reg <= 1'b0;
      end else begin
         if (pin_a_mode == PIN_GP_INPUT) begin
            pin_a_in_reg <= pin_a_sync_reg[1];
         end
         if (pin_b_mode == PIN_GP_INPUT) begin
            pin_b_in_reg <= pin_b_sync_reg[1];
         end
      end
   end
   assign o_pin_a_input_value = pin_a_in_reg;
   assign o_pin_b_input_value = pin_b_in_reg;

   // ----------------------------------------------------------------
   // datapath mode decode
   // ----------------------------------------------------------------
   wire logic pass_bit;
   wire logic pass_active;
   wire logic valid_true;
   wire logic four_ch;
   assign pass_bit = datapath_control_reg[`DP_PASS_VIDEO_BIT];
   // the bit does nothing unless the partner supports protection
   assign pass_active = pass_bit & i_partner_has_protection;
   // polarity 1 means active low, idle high
   assign valid_true = valid_sync_reg[1]
      ^ datapath_control_reg[`DP_POLARITY_BIT];
   // override 0 forces four channel off whatever the enable says
   assign four_ch = datapath_control_reg[`DP_FOUR_CH_OVR_BIT]
      & datapath_control_reg[`DP_FOUR_CH_EN_BIT];

   // datapath outputs registered so they change cleanly
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pixel_valid_active <= 1'b0;
         o_video_pass_without_framing <= 1'b0;
         o_protection_enable <= 1'b1;
         o_packet_audio_enable <= 1'b1;
         o_audio_on_video_pins <= 1'b1;
         o_four_channel_audio <= 1'b0;
         o_depth_18_bit <= 1'b0;
         o_audio_in_band <= 1'b0;
      end else begin
         o_pixel_valid_active <= pass_active | valid_true;
         o_video_pass_without_framing <= pass_active;
         o_protection_enable <= ~pass_active;
         o_packet_audio_enable <= ~pass_active;
         o_audio_on_video_pins <= ~pass_active
            & ~datapath_control_reg[`DP_REGEN_BIT];
         o_four_channel_audio <= four_ch;
         o_depth_18_bit <=
            datapath_control_reg[`DP_DEPTH_BIT];
         o_audio_in_band <=
            datapath_control_reg[`DP_TRANSPORT_BIT];
      end
   end
endmodule

/* inc/pin_dp_params.svh */
/*
 holds offsets, field positions and reset values of the pin pair
 configuration and datapath control registers.
 assumes inclusion by bare name from the package and design files.
*/
// Summary of operation
// - gp output mode drives stored local value
// - remote enable makes pin output remote value
// - decode dir,function: 00 func,10 z,01 out,11 in
// - lock bit blocks forward channel loads
// - unlocked bits 6..0 follow remote loads
// - pass video ignores data valid framing
// - pass video disables protection, blocks audio
// - pass video inert without protection partner
// - polarity bit inverts data valid sense
// - repeater regen suppresses audio on video pins
// - override picks four channel from enable bit
// - depth bit picks 18 or 24 bit
// - transport bit picks in-band or data island
// - enable bit turns on four channel audio when override bit set
`ifndef PIN_DP_PARAMS_SVH
`define PIN_DP_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PIN_PAIR_CONFIG_ADDR 8'h21
`define DATAPATH_CONTROL_ADDR 8'h22
`define PIN_PAIR_CONFIG_RESET 8'h00
`define DATAPATH_CONTROL_RESET 8'h00

// ----------------------------------------------------------------
// pin pair field positions (pin a low nibble, pin b high nibble)
// ----------------------------------------------------------------
`define PIN_A_BASE 0
`define PIN_B_BASE 4
`define PIN_FUNC_OFS 0
`define PIN_DIR_OFS 1
`define PIN_REMOTE_OFS 2
`define PIN_VALUE_OFS 3

// ----------------------------------------------------------------
// datapath control field positions
// ----------------------------------------------------------------
`define DP_LOCK_BIT 7
`define DP_PASS_VIDEO_BIT 6
`define DP_POLARITY_BIT 5
`define DP_REGEN_BIT 4
`define DP_FOUR_CH_OVR_BIT 3
`define DP_DEPTH_BIT 2
`define DP_TRANSPORT_BIT 1
`define DP_FOUR_CH_EN_BIT 0
`define DP_REMOTE_MASK 8'h7f

`endif

/* inc/pin_dp_pkg.sv */
/*
 holds the types shared by the pin pair and datapath config logic.
 assumes the params header is on the include path.
*/
package pin_dp_pkg;
`include "pin_dp_params.svh"

   // ----------------------------------------------------------------
   // pin mode, decoded from {direction, function}
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PIN_FUNCTIONAL,
      PIN_GP_OUTPUT,
      PIN_TRISTATE,
      PIN_GP_INPUT
   } pin_mode_t;
endpackage

/* hw/pin_ctrl.sv */
/*
 holds the pad control of one general purpose pin.
 assumes pin input already synchronised and remote value on core clock.
*/
`include "pin_dp_params.svh"

module pin_ctrl
   import pin_dp_pkg::*;
(
   // configuration nibble
   input wire logic [3:0] i_cfg,
   // pad sources
   input wire logic i_functional_value,
   input wire logic i_remote_value,
   // pad drive
   output logic o_pin_out,
   output logic o_pin_oe,
   output pin_mode_t o_mode
);
   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   function automatic pin_mode_t decode_mode(input logic [1:0] df);
      case (df)
         2'b00: decode_mode = PIN_FUNCTIONAL;
         2'b01: decode_mode = PIN_GP_OUTPUT;
         2'b10: decode_mode = PIN_TRISTATE;
         default: decode_mode = PIN_GP_INPUT;
      endcase
   endfunction

   wire logic remote_en;
   wire pin_mode_t mode;
   assign remote_en = i_cfg[`PIN_REMOTE_OFS];
   assign mode = decode_mode({i_cfg[`PIN_DIR_OFS],
                              i_cfg[`PIN_FUNC_OFS]});
   assign o_mode = mode;

   // remote control overrides the local mode so the far end owns the pad
   assign o_pin_oe = remote_en | (mode == PIN_FUNCTIONAL)
                     | (mode == PIN_GP_OUTPUT);
   assign o_pin_out = remote_en ? i_remote_value :
                      (mode == PIN_GP_OUTPUT) ?
                      i_cfg[`PIN_VALUE_OFS] :
                      (mode == PIN_FUNCTIONAL) ? i_functional_value :
                      1'b0;
endmodule

/* tb/pin_dp_chk.sv */
/*
 holds the port checker of the config register block.
 assumes it is bound to the top module on the core clock.
*/
module pin_dp_chk (
   // clock, reset and requests
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_remote_dp_load,
   input wire logic i_remote_pin_a_value,
   input wire logic i_partner_has_protection,
   input wire logic i_pin_a_functional,
   // observed outputs
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_pin_a_out,
   input wire logic o_pin_a_oe,
   input wire logic o_pixel_valid_active,
   input wire logic o_video_pass_without_framing,
   input wire logic o_protection_enable,
   input wire logic o_packet_audio_enable,
   input wire logic o_audio_on_video_pins,
   input wire logic o_four_channel_audio,
   input wire logic o_depth_18_bit,
   input wire logic o_audio_in_band
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // request decode
   // ----------------------------------------------------------------
   wire wr_a = i_reg_wr && i_reg_addr == 8'h21;
   wire wr_d = i_reg_wr && i_reg_addr == 8'h22;
   // quiet cycle: nothing can overwrite what was just written
   wire quiet = !i_reg_wr && !i_remote_dp_load;
   wire [1:0] wd_mode = i_reg_wdata[2:1];
   wire [1:0] cfg_a = i_reg_wdata[2:1];
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   a_gp_out_drive: assert property (
      wr_a && i_reg_wdata[2:0] == 3'b001 |=>
      o_pin_a_oe && o_pin_a_out == $past(i_reg_wdata[3]))
      else $error("pin a gp output wrong");
   a_remote_drive: assert property (
      wr_a && i_reg_wdata[2] |=>
      o_pin_a_oe && o_pin_a_out == i_remote_pin_a_value)
      else $error("pin a remote drive wrong");
   a_pad_released: assert property (
      wr_a && cfg_a == 2'b01 |=> !o_pin_a_oe)
      else $error("pin a drives while off");
   a_func_drive: assert property (
      wr_a && i_reg_wdata[2:0] == 3'b000 |=>
      o_pin_a_oe && o_pin_a_out == i_pin_a_functional)
      else $error("pin a functional drive wrong");
   a_lock_keeps: assert property (
      wr_d && i_reg_wdata[7] ##1 i_remote_dp_load && !i_reg_wr
      ##1 quiet |=> o_depth_18_bit == $past(i_reg_wdata[2], 3))
      else $error("locked value lost");
   a_four_chan: assert property (
      wr_d ##1 quiet |=> o_four_channel_audio ==
      ($past(i_reg_wdata[3], 2) & $past(i_reg_wdata[0], 2)))
      else $error("four channel audio wrong");
   a_mode_bits: assert property (
      wr_d ##1 quiet |=>
      {o_depth_18_bit, o_audio_in_band} == $past(wd_mode, 2))
      else $error("depth or transport wrong");
   a_pass_blocks: assert property (
      o_video_pass_without_framing |-> o_pixel_valid_active &&
      !o_protection_enable && !o_packet_audio_enable &&
      !o_audio_on_video_pins)
      else $error("pass mode side effects wrong");
   a_pass_inert: assert property (
      !i_partner_has_protection [*2] |-> !o_video_pass_without_framing)
      else $error("pass active without protection");
   a_read_back: assert property (
      wr_a ##1 i_reg_addr == 8'h21 && !i_reg_wr |=>
      o_reg_rdata == $past(i_reg_wdata, 2))
      else $error("read back differs");
   a_unmapped_zero: assert property (
      i_reg_addr > 8'h22 |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule

/* tb/remote_ser_model.sv */
/*
 holds a model of the remote serializer forward channel side.
 assumes load requests from the bench on the core clock.
*/
module remote_ser_model (
   // bench request
   input wire logic i_core_clk,
   input wire logic i_send,
   input wire logic [7:0] i_value,
   // forward channel toward the block
   output logic o_load = 1'b0,
   output logic [7:0] o_data = 8'h00,
   output logic o_pin_a = 1'b0,
   output logic o_pin_b = 1'b1
);
   timeunit 1ns;
   timeprecision 1ns;
   // one-cycle load; idle data inverts so stale bytes never match
   always @(posedge i_core_clk) begin
      o_load <= i_send;
      o_data <= i_send ? i_value : ~o_data;
      {o_pin_b, o_pin_a} <= {o_pin_a, ~o_pin_b};
   end
endmodule

/* tb/tb_pin_dp_config_regs.sv */
/*
 holds the self-checking bench of the config register block.
 assumes the checker and serializer model are compiled first.
*/
module tb_pin_dp_config_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_core_clk = 1'b0, i_reset_n = 1'b0, i_reg_wr = 1'b0;
   logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
   logic [7:0] i_remote_dp_data, send_val = 8'h00, dreg;
   logic send = 1'b0, i_remote_dp_load;
   logic i_remote_pin_a_value, i_remote_pin_b_value;
   logic i_partner_has_protection = 1'b0, i_pin_a = 1'b0;
   logic i_pin_b = 1'b0, i_pin_a_functional = 1'b0;
   logic i_pin_b_functional = 1'b0, i_pixel_data_valid = 1'b0;
   logic o_pin_a_out, o_pin_a_oe, o_pin_b_out, o_pin_b_oe;
   logic o_pin_a_input_value, o_pin_b_input_value;
   logic o_pixel_valid_active, o_video_pass_without_framing;
   logic o_protection_enable, o_packet_audio_enable;
   logic o_audio_on_video_pins, o_four_channel_audio;
   logic o_depth_18_bit, o_audio_in_band;
   logic [31:0] lf = 32'h0000_08c9;
   int errors = 0, num_checks = 0;

   // ----------------------------------------------------------------
   // clock, parts and helpers
   // ----------------------------------------------------------------
   always #50 i_core_clk = ~i_core_clk;
   pin_dp_config_regs i_pin_dp_config_regs (.i_core_clk, .i_reset_n,
      .i_reg_addr, .i_reg_wr, .i_reg_wdata, .o_reg_rdata,
      .i_remote_dp_load, .i_remote_dp_data, .i_remote_pin_a_value,
      .i_remote_pin_b_value, .i_partner_has_protection, .i_pin_a,
      .i_pin_b, .i_pin_a_functional, .i_pin_b_functional, .o_pin_a_out,
      .o_pin_a_oe, .o_pin_b_out, .o_pin_b_oe, .o_pin_a_input_value,
      .o_pin_b_input_value, .i_pixel_data_valid, .o_pixel_valid_active,
      .o_video_pass_without_framing, .o_protection_enable,
      .o_packet_audio_enable, .o_audio_on_video_pins,
      .o_four_channel_audio, .o_depth_18_bit, .o_audio_in_band);
   remote_ser_model i_remote_ser_model (.i_core_clk, .i_send(send),
      .i_value(send_val), .o_load(i_remote_dp_load),
      .o_data(i_remote_dp_data), .o_pin_a(i_remote_pin_a_value),
      .o_pin_b(i_remote_pin_b_value));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // pad {oe, out}; remote control wins over the mode field
   function automatic logic [1:0] epin(input logic [3:0] c,
                                       input logic r, f);
      if (c[2]) return {1'b1, r};
      case (c[1:0])
         2'b00: return {1'b1, f};
         2'b01: return {1'b1, c[3]};
         default: return 2'b00;
      endcase
   endfunction
   function automatic logic [7:0] edp(input logic [7:0] r,
                                      input logic p);
      logic ps;
      ps = r[6] & p;
      return {1'b0, ps, ~ps, ~ps, ~ps & ~r[4], r[3] & r[0], r[2], r[1]};
   endfunction
   task chk(input logic [7:0] g, e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, d, input logic s);
      @(posedge i_core_clk);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      send <= s;
      send_val <= lf[15:8];
      @(posedge i_core_clk);
      i_reg_wr <= 1'b0;
      send <= 1'b0;
   endtask
   task rd(input logic [7:0] a, e);
      @(posedge i_core_clk);
      i_reg_addr <= a;
      repeat (2) @(posedge i_core_clk);
      #1 chk(o_reg_rdata, e);
   endtask
   task end_sim;
      if (errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      rd(8'h21, 8'h00);
      rd(8'h22, 8'h00);
      rd(8'h5a, 8'h00);
      // random config, lock and remote loads mixed in
      for (int i = 0; i < 60; i++) begin
         lf = nxt(lf);
         @(posedge i_core_clk);
         i_partner_has_protection <= lf[24];
         i_pin_a_functional <= lf[25];
         i_pin_b_functional <= lf[26];
         dreg = lf[7:0];
         wr(8'h22, dreg, lf[27]);
         if (lf[27] && !dreg[7]) dreg[6:0] = lf[14:8];
         rd(8'h22, dreg);
         chk({1'b0, o_video_pass_without_framing, o_protection_enable,
            o_packet_audio_enable, o_audio_on_video_pins,
            o_four_channel_audio, o_depth_18_bit, o_audio_in_band},
            edp(dreg, i_partner_has_protection));
         wr(8'h21, lf[23:16], 1'b0);
         rd(8'h21, lf[23:16]);
         chk({4'h0, o_pin_a_oe, o_pin_a_out, o_pin_b_oe, o_pin_b_out},
            {4'h0, epin(lf[19:16], i_remote_pin_a_value,
            i_pin_a_functional), epin(lf[23:20], i_remote_pin_b_value,
            i_pin_b_functional)});
      end
      // remote load and local write meet on one edge: local wins
      @(posedge i_core_clk);
      send <= 1'b1;
      send_val <= 8'h7f;
      wr(8'h22, 8'h04, 1'b0);
      rd(8'h22, 8'h04);
      // data valid sense for both polarities, three edge path
      for (int p = 0; p < 2; p++) begin
         wr(8'h22, {2'b00, p[0], 5'h00}, 1'b0);
         for (int v = 0; v < 2; v++) begin
            @(posedge i_core_clk);
            i_pixel_data_valid <= v[0];
            repeat (4) @(posedge i_core_clk);
            #1 chk({7'h00, o_pixel_valid_active},
               {7'h00, v[0] ^ p[0]});
         end
      end
      // both pins as gp inputs
      wr(8'h21, 8'h33, 1'b0);
      i_pin_a <= lf[3];
      i_pin_b <= lf[9];
      repeat (4) @(posedge i_core_clk);
      #1 chk({o_pin_a_input_value, o_pin_b_input_value},
         {lf[3], lf[9]});
      // second reset in mid-run; pin pair register reads back cleared
      @(posedge i_core_clk);
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      rd(8'h21, 8'h00);
      end_sim();
   end
   // watchdog against a hung sequence
   initial begin
      repeat (20000) @(posedge i_core_clk);
      errors++;
      end_sim();
   end
endmodule
bind pin_dp_config_regs pin_dp_chk i_pin_dp_chk (.i_core_clk,
   .i_reset_n, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_remote_dp_load,
   .i_remote_pin_a_value, .i_partner_has_protection,
   .i_pin_a_functional, .o_reg_rdata, .o_pin_a_out, .o_pin_a_oe,
   .o_pixel_valid_active, .o_video_pass_without_framing,
   .o_protection_enable, .o_packet_audio_enable, .o_audio_on_video_pins,
   .o_four_channel_audio, .o_depth_18_bit, .o_audio_in_band);
